// *** rtl/sport_pkg.sv ***
package sport_pkg;
   // clock and time base
   localparam int CLK_HZ        = 100_000_000;
   localparam int MS_PER_TICK   = 1;
   localparam int MS_CYCLES_DEF = CLK_HZ / 1000 * MS_PER_TICK;
   localparam int TEN_MS        = 10;
   localparam logic [3:0] TEN_MS_LAST = 4'(TEN_MS - 1);
   // modem timing, held in ms ticks
   localparam int PAUSE_S       = 2;
   localparam int DIAL_TOTAL_S  = 180;
   localparam int DIAL_TRIES    = 4;
   localparam logic [15:0] PAUSE_MS = 16'(PAUSE_S * 1000);
   localparam logic [15:0] TRY_MS   = 16'(DIAL_TOTAL_S * 1000 / DIAL_TRIES);
   localparam logic [1:0]  REDIALS  = 2'd3;
   localparam logic [7:0]  GAP_DEF_MS = 8'h04;
   // baud generation
   localparam int BAUD_REF_HZ = 18_432_000;
   localparam logic [26:0] BAUD_REF = 27'(BAUD_REF_HZ);
   localparam logic [26:0] CLK_REF  = 27'(CLK_HZ);
   localparam logic [13:0] DIV_MIN  = 14'd15;
   localparam logic [13:0] DIV_MAX  = 14'd16383;
   localparam logic [15:0] DIV_RST  = 16'h077f;
   // register indices
   localparam logic [4:0] IX_P0MODE = 5'h00;
   localparam logic [4:0] IX_BYP12  = 5'h01;
   localparam logic [4:0] IX_BYP34  = 5'h02;
   localparam logic [4:0] IX_RD01   = 5'h03;
   localparam logic [4:0] IX_RD23   = 5'h04;
   localparam logic [4:0] IX_RD4    = 5'h05;
   localparam logic [4:0] IX_TM1    = 5'h06;
   localparam logic [4:0] IX_GAP    = 5'h0a;
   localparam logic [4:0] IX_PH0    = 5'h0b;
   localparam logic [4:0] IX_CTRL   = 5'h11;
   localparam logic [4:0] IX_BAUD1  = 5'h12;
   localparam logic [4:0] IX_STATUS = 5'h16;
   localparam int         RW_COUNT  = 22;
   localparam logic [15:0] REG_RST  = 16'h0000;
   localparam int CTRL_GAP_OVR = 0;
   // field codes
   localparam logic [7:0] MODE_PROG  = 8'h55;
   localparam logic [7:0] MODE_DIAL  = 8'haa;
   localparam logic [7:0] BYPASS_ON  = 8'h01;
   localparam logic [7:0] STATION_ANY = 8'hff;
   localparam logic [3:0] NIB_PAUSE  = 4'ha;
   localparam logic [3:0] NIB_MAX    = 4'hc;
   localparam logic [3:0] NIB_END    = 4'he;
   localparam int PHONE_NIBS = 24;

   typedef enum logic [5:0] {
      M_OFF    = 6'h01,
      M_DIAL   = 6'h02,
      M_PAUSE  = 6'h04,
      M_WAIT   = 6'h08,
      M_ANSWER = 6'h10,
      M_LINKED = 6'h20
   } modem_state_type;

   typedef struct packed {
      logic [4:0]      valid;
      logic [4:0]      internal;
      logic [4:0][7:0] station;
   } req_in_type;

   typedef struct packed {
      logic [3:0] tx_req;
      logic [3:0] rx_resp;
      logic [3:0] rx_byte;
      logic [3:0] modbus;
      logic [3:0] no_etx;
   } mst_in_type;
endpackage

// *** rtl/sport_ctrl.sv ***
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module sport_ctrl
   import sport_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       ce,
   input  wire logic [4:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [15:0] reg_rdata,
   input  wire logic [7:0] own_station,
   input  wire req_in_type req,
   input  wire mst_in_type mst,
   input  wire logic       modem_pwr,
   input  wire logic       modem_dcd,
   input  wire logic       callback,
   output var  logic [4:0] req_accept,
   output var  logic [4:0] reply_go,
   output var  logic [3:0] tx_go,
   output var  logic [3:0] slave_offline,
   output var  logic [3:0] frame_gap,
   output var  logic [3:0] baud_tick,
   output var  logic       port1_modem_hold,
   output var  logic       modem_answer,
   output var  logic       dial_strobe,
   output var  logic [3:0] dial_code
);
   logic [15:0]     regs_r [RW_COUNT];
   logic [16:0]     ms_cnt_r;
   logic            ms_tick_r;
   logic [3:0]      ten_cnt_r;
   logic            ten_tick_r;
   logic [4:0]      rbusy_r;
   logic [7:0]      rcnt_r [5];
   logic [3:0]      tbusy_r;
   logic [3:0]      wait_r;
   logic [7:0]      tcnt_r [4];
   logic [7:0]      gcnt_r [4];
   logic [3:0]      garm_r;
   logic [3:0]      done_r;
   logic [3:0]      ready;
   logic [7:0]      bypass [5];
   logic [7:0]      rdly [5];
   logic [4:0]      acc_nxt;
   logic [7:0]      gap_ms [4];
   logic [26:0]     bacc_r;
   logic            bref_r;
   logic [13:0]     bcnt_r [4];
   logic            dcd_s1_r;
   logic            dcd_s2_r;
   logic            pwr_s1_r;
   logic            pwr_s2_r;
   logic            pwr_d_r;
   logic            boot_r;
   logic            pwr_evt;
   modem_state_type state_r;
   logic [95:0]     phone_r;
   logic [95:0]     phone_live;
   logic [4:0]      idx_r;
   logic [1:0]      tries_r;
   logic [15:0]     mtmr_r;
   logic [3:0]      nib;
   logic [7:0]      mode;

   // whole number valid: end marker present, digits 0-c before it
   function automatic logic phone_ok(input logic [95:0] ph);
      logic ended;
      logic bad;
      ended = 1'b0;
      bad   = 1'b0;
      for (int i = 0; i < PHONE_NIBS; i++) begin
         if (!ended) begin
            if (ph[4*i +: 4] == NIB_END) begin
               ended = 1'b1;
            end else if (ph[4*i +: 4] > NIB_MAX) begin
               bad = 1'b1;
            end
         end
      end
      // an end marker in the first nibble leaves nothing to dial
      return ended && !bad && (ph[3:0] != NIB_END);
   endfunction

   // clamp a divisor to its legal span
   function automatic logic [13:0] clamp_div(input logic [15:0] d);
      if (d < 16'(DIV_MIN)) begin
         return DIV_MIN;
      end else if (d > 16'(DIV_MAX)) begin
         return DIV_MAX;
      end
      return d[13:0];
   endfunction

   // field views of the register file
   always_comb begin
      bypass[0] = regs_r[IX_P0MODE][7:0];
      bypass[1] = regs_r[IX_BYP12][7:0];
      bypass[2] = regs_r[IX_BYP12][15:8];
      bypass[3] = regs_r[IX_BYP34][7:0];
      bypass[4] = regs_r[IX_BYP34][15:8];
      rdly[0]   = regs_r[IX_RD01][7:0];
      rdly[1]   = regs_r[IX_RD01][15:8];
      rdly[2]   = regs_r[IX_RD23][7:0];
      rdly[3]   = regs_r[IX_RD23][15:8];
      rdly[4]   = regs_r[IX_RD4][7:0];
      mode      = regs_r[IX_P0MODE][15:8];
      for (int w = 0; w < 6; w++) begin
         phone_live[16*w +: 16] = regs_r[IX_PH0 + 5'(w)];
      end
      nib = phone_r[{idx_r, 2'b00} +: 4];
   end

   // request acceptance per port
   always_comb begin
      for (int p = 0; p < 5; p++) begin
         if (req.internal[p]) begin
            acc_nxt[p] = (req.station[p] == STATION_ANY)
                         || (req.station[p] == own_station);
         end else begin
            acc_nxt[p] = (bypass[p] == BYPASS_ON)
                         || (req.station[p] == own_station);
         end
         acc_nxt[p] = acc_nxt[p] && req.valid[p];
      end
      acc_nxt[1] = acc_nxt[1] && !port1_modem_hold;
   end

   // gap source: link protocol always uses byte, modbus only on override
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         if (mst.no_etx[k] || regs_r[IX_CTRL][CTRL_GAP_OVR]) begin
            gap_ms[k] = regs_r[IX_GAP][15:8];
         end else begin
            gap_ms[k] = GAP_DEF_MS;
         end
         ready[k] = !(rbusy_r[k+1] || tbusy_r[k] || wait_r[k]);
      end
   end

   // register writes; finished bits clear by writing ones to status
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < RW_COUNT; i++) begin
            regs_r[i] <= (i >= int'(IX_BAUD1)) ? DIV_RST : REG_RST;
         end
      end else if (ce && reg_wr && (int'(reg_addr) < RW_COUNT)) begin
         regs_r[reg_addr] <= reg_wdata;
      end
   end

   // read data one cycle after the strobe, zero elsewhere
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 16'h0000;
      end else if (ce) begin
         if (!reg_rd) begin
            reg_rdata <= 16'h0000;
         end else if (reg_addr == IX_STATUS) begin
            reg_rdata <= {2'b00, state_r, done_r, ready};
         end else if (int'(reg_addr) < RW_COUNT) begin
            reg_rdata <= regs_r[reg_addr];
         end else begin
            reg_rdata <= 16'h0000;
         end
      end
   end

   // 1 ms and 10 ms ticks
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ms_cnt_r   <= 17'h00000;
         ms_tick_r  <= 1'b0;
         ten_cnt_r  <= 4'h0;
         ten_tick_r <= 1'b0;
      end else if (ce) begin
         ms_tick_r  <= (ms_cnt_r == 17'(MS_CYCLES - 1));
         ten_tick_r <= 1'b0;
         if (ms_cnt_r == 17'(MS_CYCLES - 1)) begin
            ms_cnt_r <= 17'h00000;
            ten_cnt_r <= (ten_cnt_r == TEN_MS_LAST) ? 4'h0 : ten_cnt_r + 4'h1;
            ten_tick_r <= (ten_cnt_r == TEN_MS_LAST);
         end else begin
            ms_cnt_r <= ms_cnt_r + 17'h00001;
         end
      end
   end

   // slave side: accept, then hold the reply for the port's delay
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         req_accept <= 5'h00;
         reply_go   <= 5'h00;
         rbusy_r    <= 5'h00;
         for (int p = 0; p < 5; p++) begin
            rcnt_r[p] <= 8'h00;
         end
      end else if (ce) begin
         req_accept <= acc_nxt;
         reply_go   <= 5'h00;
         for (int p = 0; p < 5; p++) begin
            if (acc_nxt[p]) begin
               rbusy_r[p] <= 1'b1;
               rcnt_r[p]  <= rdly[p];
            end else if (rbusy_r[p]) begin
               if (rcnt_r[p] == 8'h00) begin
                  reply_go[p] <= 1'b1;
                  rbusy_r[p]  <= 1'b0;
               end else if (ms_tick_r) begin
                  rcnt_r[p] <= rcnt_r[p] - 8'h01;
               end
            end
         end
      end
   end

   // master side: transmit delay, then response timeout
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tx_go         <= 4'h0;
         slave_offline <= 4'h0;
         tbusy_r       <= 4'h0;
         wait_r        <= 4'h0;
         for (int k = 0; k < 4; k++) begin
            tcnt_r[k] <= 8'h00;
         end
      end else if (ce) begin
         tx_go         <= 4'h0;
         slave_offline <= 4'h0;
         for (int k = 0; k < 4; k++) begin
            if (mst.tx_req[k] && !tbusy_r[k]) begin
               tbusy_r[k] <= 1'b1;
               wait_r[k]  <= 1'b0;
               tcnt_r[k]  <= regs_r[IX_TM1 + 5'(k)][15:8];
            end else if (tbusy_r[k]) begin
               if (tcnt_r[k] == 8'h00) begin
                  tx_go[k]   <= 1'b1;
                  tbusy_r[k] <= 1'b0;
                  wait_r[k]  <= 1'b1;
                  tcnt_r[k]  <= regs_r[IX_TM1 + 5'(k)][7:0];
               end else if (ten_tick_r) begin
                  tcnt_r[k] <= tcnt_r[k] - 8'h01;
               end
            end else if (wait_r[k]) begin
               if (mst.rx_resp[k]) begin
                  wait_r[k] <= 1'b0;
               end else if (tcnt_r[k] == 8'h00) begin
                  slave_offline[k] <= 1'b1;
                  wait_r[k]        <= 1'b0;
               end else if (ten_tick_r) begin
                  tcnt_r[k] <= tcnt_r[k] - 8'h01;
               end
            end
         end
      end
   end

   // finished bits: hardware set beats a software clear
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         done_r <= 4'h0;
      end else if (ce) begin
         for (int k = 0; k < 4; k++) begin
            if (reply_go[k+1] || slave_offline[k]
                || (wait_r[k] && mst.rx_resp[k])) begin
               done_r[k] <= 1'b1;
            end else if (reg_wr && reg_addr == IX_STATUS && reg_wdata[4+k]) begin
               done_r[k] <= 1'b0;
            end
         end
      end
   end

   // idle gap after the last byte marks a frame boundary
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         frame_gap <= 4'h0;
         garm_r    <= 4'h0;
         for (int k = 0; k < 4; k++) begin
            gcnt_r[k] <= 8'h00;
         end
      end else if (ce) begin
         frame_gap <= 4'h0;
         for (int k = 0; k < 4; k++) begin
            if (mst.rx_byte[k]) begin
               garm_r[k] <= mst.modbus[k] || mst.no_etx[k];
               gcnt_r[k] <= gap_ms[k];
            end else if (garm_r[k]) begin
               if (gcnt_r[k] == 8'h00) begin
                  frame_gap[k] <= 1'b1;
                  garm_r[k]    <= 1'b0;
               end else if (ms_tick_r) begin
                  gcnt_r[k] <= gcnt_r[k] - 8'h01;
               end
            end
         end
      end
   end

   // baud: fractional 18.432 MHz enable, then divide by divisor plus one
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bacc_r    <= 27'h0000000;
         bref_r    <= 1'b0;
         baud_tick <= 4'h0;
         for (int k = 0; k < 4; k++) begin
            bcnt_r[k] <= 14'h0000;
         end
      end else if (ce) begin
         if (bacc_r + BAUD_REF >= CLK_REF) begin
            bacc_r <= bacc_r + BAUD_REF - CLK_REF;
            bref_r <= 1'b1;
         end else begin
            bacc_r <= bacc_r + BAUD_REF;
            bref_r <= 1'b0;
         end
         baud_tick <= 4'h0;
         for (int k = 0; k < 4; k++) begin
            if (bref_r) begin
               if (bcnt_r[k] >= clamp_div(regs_r[IX_BAUD1 + 5'(k)])) begin
                  bcnt_r[k]    <= 14'h0000;
                  baud_tick[k] <= 1'b1;
               end else begin
                  bcnt_r[k] <= bcnt_r[k] + 14'h0001;
               end
            end
         end
      end
   end

   // pin synchronisers; first stage feeds the second only
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dcd_s1_r <= 1'b0;
         dcd_s2_r <= 1'b0;
         pwr_s1_r <= 1'b0;
         pwr_s2_r <= 1'b0;
         pwr_d_r  <= 1'b0;
         boot_r   <= 1'b0;
      end else if (ce) begin
         dcd_s1_r <= modem_dcd;
         dcd_s2_r <= dcd_s1_r;
         pwr_s1_r <= modem_pwr;
         pwr_s2_r <= pwr_s1_r;
         pwr_d_r  <= pwr_s2_r;
         boot_r   <= 1'b1;
      end
   end

   // controller power-up counts as the first power event
   assign pwr_evt = !boot_r || (pwr_s2_r && !pwr_d_r);

   // modem dialer; the number is sampled only at a power event or callback
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_r     <= M_OFF;
         phone_r     <= 96'h0;
         idx_r       <= 5'h00;
         tries_r     <= 2'd0;
         mtmr_r      <= 16'h0000;
         dial_strobe <= 1'b0;
         dial_code   <= 4'h0;
      end else if (ce) begin
         dial_strobe <= 1'b0;
         if (pwr_evt) begin
            phone_r <= phone_live;
            idx_r   <= 5'h00;
            tries_r <= 2'd0;
            if (mode == MODE_DIAL) begin
               state_r <= phone_ok(phone_live) ? M_DIAL : M_ANSWER;
            end else if (mode == MODE_PROG) begin
               state_r <= M_ANSWER;
            end else begin
               state_r <= M_OFF;
            end
         end else begin
            case (state_r)
               M_DIAL: if (ms_tick_r) begin
                  if (nib == NIB_END) begin
                     state_r <= M_WAIT;
                     mtmr_r  <= TRY_MS;
                  end else if (nib == NIB_PAUSE) begin
                     state_r <= M_PAUSE;
                     mtmr_r  <= PAUSE_MS;
                     idx_r   <= idx_r + 5'h01;
                  end else begin
                     dial_strobe <= 1'b1;
                     dial_code   <= nib;
                     idx_r       <= idx_r + 5'h01;
                  end
               end
               M_PAUSE: if (ms_tick_r) begin
                  if (mtmr_r == 16'h0000) begin
                     state_r <= M_DIAL;
                  end else begin
                     mtmr_r <= mtmr_r - 16'h0001;
                  end
               end
               M_WAIT: begin
                  if (dcd_s2_r) begin
                     state_r <= M_LINKED;
                  end else if (ms_tick_r && mtmr_r == 16'h0000) begin
                     idx_r <= 5'h00;
                     if (tries_r == REDIALS) begin
                        state_r <= M_ANSWER;
                     end else begin
                        tries_r <= tries_r + 2'd1;
                        state_r <= M_DIAL;
                     end
                  end else if (ms_tick_r) begin
                     mtmr_r <= mtmr_r - 16'h0001;
                  end
               end
               M_ANSWER: if (dcd_s2_r) begin
                  state_r <= M_LINKED;
               end
               M_LINKED: begin
                  if (callback) begin
                     phone_r <= phone_live;
                     idx_r   <= 5'h00;
                     tries_r <= 2'd0;
                     state_r <= phone_ok(phone_live) ? M_DIAL : M_ANSWER;
                  end else if (!dcd_s2_r) begin
                     state_r <= M_ANSWER;
                  end
               end
               default: state_r <= M_OFF;
            endcase
         end
      end
   end

   // port 1 is held by the dialer in the dial mode until linked
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         port1_modem_hold <= 1'b0;
         modem_answer     <= 1'b0;
      end else if (ce) begin
         port1_modem_hold <= (mode == MODE_DIAL) && (state_r != M_LINKED);
         modem_answer     <= (state_r == M_ANSWER);
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence s_wait_expire;
      wait_r[0] && tcnt_r[0] == 8'h00 && !mst.rx_resp[0] && !mst.tx_req[0] && ce;
   endsequence

   AST_BYPASS: assert property (ce && req.valid[0] && !req.internal[0]
      && bypass[0] == BYPASS_ON |=> req_accept[0])
      else $error("bypass request not accepted");
   AST_STATION_ANY: assert property (ce && req.valid[2] && req.internal[2]
      && req.station[2] == STATION_ANY |=> req_accept[2])
      else $error("station 255 request not accepted");
   AST_ZERO_DELAY: assert property (ce && acc_nxt[0] && rdly[0] == 8'h00
      ##1 ce |=> reply_go[0])
      else $error("zero delay reply late");
   AST_NO_EARLY: assert property (acc_nxt[0] && ce && rdly[0] > 8'h01
      |=> !reply_go[0] [*2])
      else $error("reply before its delay");
   AST_TIMEOUT: assert property (s_wait_expire |=> slave_offline[0])
      else $error("timeout did not mark slave offline");
   AST_DONE: assert property (slave_offline[0] && ce |=> done_r[0])
      else $error("finished bit not set");
   AST_HOLD: assert property (port1_modem_hold && $past(port1_modem_hold)
      |-> !req_accept[1])
      else $error("port 1 accepted while held");
   AST_RETRY: assert property (state_r == M_ANSWER
      && $past(state_r) == M_WAIT && !$past(pwr_evt) |-> $past(tries_r) == REDIALS)
      else $error("answer mode before last redial");
   AST_DIGIT: assert property (dial_strobe |-> dial_code <= NIB_MAX
      && dial_code != NIB_PAUSE)
      else $error("bad digit dialed");
endmodule
`default_nettype wire

// *** verif/remote_modem.sv ***
`timescale 1ns/10ps
`default_nettype none
// far-end modem: picks up once the expected digits have been dialled
module remote_modem #(
   parameter int DIGITS = 2
) (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic dial_strobe,
   input  wire logic hang_up,
   output var  logic modem_dcd
);
   int seen;
   int ring_n;
   // slow answer: carrier rises well after the last digit, never before
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         seen <= 0;
         ring_n <= 0;
         modem_dcd <= 1'b0;
      end else if (hang_up) begin
         // shutdown from the far end drops the carrier at once
         seen <= 0;
         ring_n <= 0;
         modem_dcd <= 1'b0;
      end else begin
         if (dial_strobe) seen <= seen + 1;
         if (seen >= DIGITS && ring_n < 40) ring_n <= ring_n + 1;
         modem_dcd <= (ring_n >= 40);
      end
   end
endmodule
`default_nettype wire

// *** verif/test_sport_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_sport_ctrl;
   import sport_pkg::*;
   localparam int MSC = 10;
   localparam int BAUD_CYC = (int'(DIV_MIN) + 1) * CLK_HZ / BAUD_REF_HZ;
   logic        ref_clk, nrst, ce, reg_wr, reg_rd, modem_pwr, modem_dcd, callback, hang_up;
   logic [4:0]  reg_addr, req_accept, reply_go;
   logic [15:0] reg_wdata, reg_rdata, rv;
   logic [7:0]  own_station;
   logic [3:0]  tx_go, slave_offline, frame_gap, baud_tick, dial_code;
   logic        port1_modem_hold, modem_answer, dial_strobe;
   req_in_type  req;
   mst_in_type  mst;
   int          errors, n_compared, cnt;
   sport_ctrl #(.MS_CYCLES(MSC)) u_sport_ctrl (.ref_clk(ref_clk), .nrst(nrst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .own_station(own_station), .req(req), .mst(mst),
      .modem_pwr(modem_pwr), .modem_dcd(modem_dcd), .callback(callback),
      .req_accept(req_accept), .reply_go(reply_go), .tx_go(tx_go),
      .slave_offline(slave_offline), .frame_gap(frame_gap), .baud_tick(baud_tick),
      .port1_modem_hold(port1_modem_hold), .modem_answer(modem_answer),
      .dial_strobe(dial_strobe), .dial_code(dial_code));
   remote_modem #(.DIGITS(2)) u_remote_modem (.ref_clk(ref_clk), .nrst(nrst),
      .dial_strobe(dial_strobe), .hang_up(hang_up), .modem_dcd(modem_dcd));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task chk16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // one request pulse; accept shows in the cycle after it is taken
   task send_req(input int p, input logic intl, input logic [7:0] st, input logic acc);
      @(posedge ref_clk);
      req.valid[p] <= 1'b1;
      req.internal[p] <= intl;
      req.station[p] <= st;
      @(posedge ref_clk);
      req.valid[p] <= 1'b0;
      #1 chk16(16'(req_accept[p]), 16'(acc));
   endtask
   // bounded wait so a lost pulse ends as a mismatch, not a hang
   task wait_strobe();
      // step off the edge so a strobe that is just ending is not seen again
      #1 cnt = 0;
      while (dial_strobe !== 1'b1 && cnt < 300) begin
         @(posedge ref_clk);
         #1 cnt++;
      end
      chk16(16'(cnt < 300), 16'h0001);
   endtask
   // one received byte, then time the idle gap to the frame boundary
   task gap_run(input int k, input int g);
      @(posedge ref_clk);
      mst.rx_byte[k] <= 1'b1;
      @(posedge ref_clk);
      mst.rx_byte[k] <= 1'b0;
      #1 cnt = 1;
      while (frame_gap[k] !== 1'b1 && cnt < 300) begin
         @(posedge ref_clk);
         #1 cnt++;
      end
      chk16(16'(cnt >= 3 + (g - 1) * MSC && cnt <= 2 + g * MSC), 16'h0001);
   endtask
   // poll the status word until the modem state shows up, bounded
   task wait_state(input logic [5:0] s);
      cnt = 0;
      rv = '0;
      while (rv[13:8] !== s && cnt < 40) begin
         rd(IX_STATUS, rv);
         cnt++;
      end
      chk16(16'(rv[13:8]), 16'(s));
   endtask
   // drop and restore modem power for a fresh power event
   task pwr_cycle();
      @(posedge ref_clk);
      modem_pwr <= 1'b0;
      repeat (4) @(posedge ref_clk);
      modem_pwr <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask
   task results();
      $display("errors=%0d compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      #200_000;
      errors++;
      results();
   end
   initial begin
      {nrst, reg_wr, reg_rd, modem_pwr, callback, hang_up, errors, n_compared} = '0;
      {reg_addr, reg_wdata, req, mst} = '0;
      mst.modbus[1] = 1'b1;
      mst.no_etx[2] = 1'b1;
      ce = 1'b1;
      own_station = 8'h01;
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      wr(IX_BYP12, 16'h0001);
      rd(IX_BYP12, rv);
      chk16(rv, 16'h0001);
      wr(IX_P0MODE, 16'h0001);
      send_req(0, 1'b0, 8'h07, 1'b1);
      rd(5'h17, rv);
      chk16(rv, 16'h0000);
      send_req(1, 1'b0, 8'h07, 1'b1);
      send_req(2, 1'b0, 8'h07, 1'b0);
      send_req(2, 1'b1, STATION_ANY, 1'b1);
      @(posedge ref_clk);
      #1 chk16(16'(reply_go[2]), 16'h0001);
      wr(IX_RD01, 16'h0302);
      send_req(1, 1'b1, 8'h01, 1'b1);
      cnt = 1;
      while (reply_go[1] !== 1'b1 && cnt < 60) begin
         @(posedge ref_clk);
         #1 cnt++;
      end
      chk16(16'(cnt >= 2 + 2 * MSC && cnt <= 2 + 3 * MSC), 16'h0001);
      send_req(0, 1'b1, 8'h01, 1'b1);
      // dial mode with number 2,1 then end marker, sampled at power event
      wr(IX_P0MODE, {MODE_DIAL, 8'h00});
      wr(IX_PH0, 16'h0e12);
      @(posedge ref_clk);
      modem_pwr <= 1'b1;
      wait_strobe();
      chk16(16'(dial_code), 16'h0002);
      @(posedge ref_clk);
      wait_strobe();
      chk16(16'(dial_code), 16'h0001);
      chk16(16'(port1_modem_hold), 16'h0001);
      send_req(1, 1'b1, STATION_ANY, 1'b0);
      wait_state(6'h20);
      chk16(16'(port1_modem_hold), 16'h0000);
      // tool reads the old number, writes a new one, then calls back
      rd(IX_PH0, rv);
      chk16(rv, 16'h0e12);
      wr(IX_PH0, 16'h0e34);
      @(posedge ref_clk);
      callback <= 1'b1;
      @(posedge ref_clk);
      callback <= 1'b0;
      wait_strobe();
      chk16(16'(dial_code), 16'h0004);
      @(posedge ref_clk);
      wait_strobe();
      chk16(16'(dial_code), 16'h0003);
      wait_state(6'h20);
      // shutdown drops the carrier; the dialer falls back to answering
      hang_up <= 1'b1;
      wait_state(6'h10);
      chk16(16'(modem_answer), 16'h0001);
      // mode byte decoded at each power event
      wr(IX_P0MODE, 16'h0000);
      pwr_cycle();
      wait_state(6'h01);
      wr(IX_P0MODE, {MODE_PROG, 8'h00});
      pwr_cycle();
      wait_state(6'h10);
      chk16(16'({port1_modem_hold, modem_answer}), 16'h0001);
      // frame gaps: default, shared byte without end marker, override
      gap_run(1, int'(GAP_DEF_MS));
      wr(IX_GAP, 16'h0200);
      gap_run(2, 2);
      wr(IX_CTRL, 16'h0001);
      gap_run(1, 2);
      // master: 1 x 10 ms transmit delay, 2 x 10 ms timeout, no answer
      wr(IX_STATUS, 16'h00f0);
      rd(IX_STATUS, rv);
      chk16(16'(rv[7:0]), 16'h000f);
      wr(IX_TM1, 16'h0102);
      @(posedge ref_clk);
      mst.tx_req[0] <= 1'b1;
      @(posedge ref_clk);
      mst.tx_req[0] <= 1'b0;
      #1 cnt = 1;
      while (tx_go[0] !== 1'b1 && cnt < 300) begin
         @(posedge ref_clk);
         #1 cnt++;
      end
      chk16(16'(cnt >= 3 && cnt <= 2 + TEN_MS * MSC), 16'h0001);
      rd(IX_STATUS, rv);
      chk16(16'(rv[3:0]), 16'h000e);
      cnt = 2;
      while (slave_offline[0] !== 1'b1 && cnt < 400) begin
         @(posedge ref_clk);
         #1 cnt++;
      end
      chk16(16'(cnt), 16'(2 * TEN_MS * MSC));
      rd(IX_STATUS, rv);
      chk16(16'(rv[7:0]), 16'h001f);
      // baud: a divisor below the floor runs as the floor
      wr(IX_BAUD1, 16'h0003);
      #1 cnt = 0;
      while (baud_tick[0] !== 1'b1 && cnt < 300) begin
         @(posedge ref_clk);
         #1 cnt++;
      end
      cnt = 0;
      do begin
         @(posedge ref_clk);
         #1 cnt++;
      end while (baud_tick[0] !== 1'b1 && cnt < 300);
      chk16(16'(cnt >= BAUD_CYC && cnt <= BAUD_CYC + 1), 16'h0001);
      results();
   end
endmodule
`default_nettype wire
